//--- dcmp_map.vh
// register map, field positions and timing constants of the compare stage
`ifndef DCMP_MAP_VH
`define DCMP_MAP_VH

// register byte offsets
`define DCMP_OFS_CMD_DIST     5'h00
`define DCMP_OFS_TABLE_PORT   5'h04
`define DCMP_OFS_CTRL         5'h08
`define DCMP_OFS_STATUS       5'h0c
`define DCMP_OFS_MEM_ERR      5'h10
`define DCMP_OFS_IRQ_STATUS   5'h14
`define DCMP_OFS_IRQ_MASK     5'h18

// control register fields
`define DCMP_CTRL_RUN_EN      31
`define DCMP_CTRL_TABLE_CLR   30
`define DCMP_CTRL_CLK_SEL     29
`define DCMP_CTRL_FORCE_VAL   27
`define DCMP_CTRL_FORCE_WE    26
`define DCMP_CTRL_POL         25

// status register fields
`define DCMP_STAT_OUT         31
`define DCMP_STAT_WPTR_HI     23
`define DCMP_STAT_WPTR_LO     12
`define DCMP_STAT_CPTR_HI     11
`define DCMP_STAT_CPTR_LO     0

// memory error status field
`define DCMP_MEMERR_BIT       0

// interrupt status and mask fields
`define DCMP_IRQ_TOGGLE       0
`define DCMP_IRQ_DONE         1
`define DCMP_IRQ_MEMERR       2
`define DCMP_IRQ_WIDTH        3

// table geometry
`define DCMP_PTR_WIDTH        12
`define DCMP_TABLE_DEPTH      4096
`define DCMP_TABLE_LAST       12'hfff

// interpolation timing
`define DCMP_PERIOD_WIDTH     24
`define DCMP_PERIOD_MAX       24'hffffff
`define DCMP_DIV_STEPS        6'h20
`define DCMP_RESET_CMD        32'h00000000

`endif

//--- dcmp_div.v
// sequential divider that turns a distance step into a per-cycle increment
`timescale 1ns/10ps
`include "dcmp_map.vh"

module dcmp_div (
  // clock and reset
  input  wire                           CLK_SYS,
  input  wire                           RESETN,
  // request
  input  wire                           START,
  input  wire [31:0]                    DIVIDEND,
  input  wire [`DCMP_PERIOD_WIDTH-1:0]  DIVISOR,
  // answer
  output reg                            DONE,
  output reg  [31:0]                    QUOTIENT
);

  reg  [31:0]                    dvd_reg;
  reg  [`DCMP_PERIOD_WIDTH:0]    rem_reg;
  reg  [`DCMP_PERIOD_WIDTH-1:0]  dvs_reg;
  reg  [5:0]                     cnt_reg;
  reg                            busy_reg;
  wire [`DCMP_PERIOD_WIDTH:0]    rem_shift;
  wire                           fits;

  // one quotient bit per cycle, restoring style
  assign rem_shift = {rem_reg[`DCMP_PERIOD_WIDTH-1:0], dvd_reg[31]};
  assign fits      = (rem_shift >= {1'b0, dvs_reg});

  // restart on every request so a late step never blocks the next one
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      dvd_reg  <= 32'h00000000;
      rem_reg  <= {(`DCMP_PERIOD_WIDTH+1){1'b0}};
      dvs_reg  <= {`DCMP_PERIOD_WIDTH{1'b0}};
      cnt_reg  <= 6'h00;
      busy_reg <= 1'b0;
      DONE     <= 1'b0;
      QUOTIENT <= 32'h00000000;
    end else begin
      DONE <= 1'b0;
      if (START) begin
        dvd_reg  <= DIVIDEND;
        dvs_reg  <= DIVISOR;
        rem_reg  <= {(`DCMP_PERIOD_WIDTH+1){1'b0}};
        cnt_reg  <= `DCMP_DIV_STEPS;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg  <= fits ? (rem_shift - {1'b0, dvs_reg}) : rem_shift;
        dvd_reg  <= {dvd_reg[30:0], fits};
        cnt_reg  <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy_reg <= 1'b0;
          DONE     <= 1'b1;
          QUOTIENT <= {dvd_reg[30:0], fits};
        end
      end
    end
  end

endmodule

//--- dcmp_top.v
// distance compare output stage with interpolator and comparison table
`timescale 1ns/10ps
`include "dcmp_map.vh"

module dcmp_top (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        RESETN,
  // interpolation clocks from the clock source
  input  wire        SERVO_CLK,
  input  wire        PHASE_CLK,
  // register port
  input  wire [4:0]  ADDR,
  input  wire [31:0] WR_DATA,
  input  wire        WR_STB,
  input  wire        RD_STB,
  output reg  [31:0] RD_DATA,
  // laser trigger and interrupt
  output wire        TRIGGER_OUTPUT_PIN,
  output wire        IRQ
);

  localparam PW = `DCMP_PTR_WIDTH;
  localparam TW = `DCMP_PERIOD_WIDTH;

  // software visible state
  reg  [31:0]           cmd_dist_reg;
  reg                   run_en_reg;
  reg                   clk_sel_reg;
  reg                   pol_reg;
  reg                   out_reg;
  reg  [PW-1:0]         wptr_reg;
  reg  [PW-1:0]         cptr_reg;
  reg                   mem_err_reg;
  reg  [`DCMP_IRQ_WIDTH-1:0] irq_stat_reg;
  reg  [`DCMP_IRQ_WIDTH-1:0] irq_mask_reg;

  // table storage, one parity bit per entry
  reg  [32:0]           table_mem [0:`DCMP_TABLE_DEPTH-1];

  // pin synchronisers
  reg                   servo_s1_reg;
  reg                   servo_s2_reg;
  reg                   servo_s3_reg;
  reg                   phase_s1_reg;
  reg                   phase_s2_reg;
  reg                   phase_s3_reg;

  // interpolator state
  reg  [TW-1:0]         period_cnt_reg;
  reg  [TW-1:0]         period_reg;
  reg  [31:0]           cap_reg;
  reg  [31:0]           seg_end_reg;
  reg  [31:0]           pos_reg;
  reg  [31:0]           step_reg;
  reg                   ramp_reg;

  // decoded accesses
  wire                  wr_cmd;
  wire                  wr_table;
  wire                  wr_ctrl;
  wire                  wr_irq_stat;
  wire                  wr_irq_mask;
  wire                  interp_edge;
  wire                  div_done;
  wire [31:0]           div_quot;
  wire [31:0]           seg_delta;
  wire [32:0]           pos_sum;
  wire [32:0]           cur_entry;
  wire                  cur_parity_bad;
  wire                  table_full;
  wire                  cmp_pending;
  wire                  cmp_hit;
  wire                  force_we;
  wire                  run_rise;
  wire                  run_fall;
  wire                  done_event;
  wire [`DCMP_IRQ_WIDTH-1:0] irq_set;

  // write strobes per register
  assign wr_cmd      = WR_STB && (ADDR == `DCMP_OFS_CMD_DIST);
  assign wr_table    = WR_STB && (ADDR == `DCMP_OFS_TABLE_PORT);
  assign wr_ctrl     = WR_STB && (ADDR == `DCMP_OFS_CTRL);
  assign wr_irq_stat = WR_STB && (ADDR == `DCMP_OFS_IRQ_STATUS);
  assign wr_irq_mask = WR_STB && (ADDR == `DCMP_OFS_IRQ_MASK);

  // command distance, captured later on the interpolation clock
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cmd_dist_reg <= `DCMP_RESET_CMD;
    end else if (wr_cmd) begin
      cmd_dist_reg <= WR_DATA;
    end
  end

  // clock pins come from another board, so two flops before any use
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      servo_s1_reg <= 1'b0;
      servo_s2_reg <= 1'b0;
      servo_s3_reg <= 1'b0;
      phase_s1_reg <= 1'b0;
      phase_s2_reg <= 1'b0;
      phase_s3_reg <= 1'b0;
    end else begin
      servo_s1_reg <= SERVO_CLK;
      servo_s2_reg <= servo_s1_reg;
      servo_s3_reg <= servo_s2_reg;
      phase_s1_reg <= PHASE_CLK;
      phase_s2_reg <= phase_s1_reg;
      phase_s3_reg <= phase_s2_reg;
    end
  end

  assign interp_edge = clk_sel_reg ? (phase_s2_reg & ~phase_s3_reg)
                                   : (servo_s2_reg & ~servo_s3_reg);

  // period measured, relies on matched clock settings upstream
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      period_cnt_reg <= {TW{1'b0}};
      period_reg     <= `DCMP_PERIOD_MAX;
    end else if (interp_edge) begin
      period_cnt_reg <= {TW{1'b0}};
      period_reg     <= period_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
    end else if (period_cnt_reg != `DCMP_PERIOD_MAX) begin
      period_cnt_reg <= period_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // a falling distance gives no ramp; the clamp below settles it once the zero step loads
  assign seg_delta = (cap_reg > seg_end_reg) ? (cap_reg - seg_end_reg)
                                             : 32'h00000000;

  // per-cycle increment for the coming interval
  dcmp_div u_div (
    .CLK_SYS  (CLK_SYS),
    .RESETN   (RESETN),
    .START    (interp_edge),
    .DIVIDEND (seg_delta),
    .DIVISOR  (period_reg),
    .DONE     (div_done),
    .QUOTIENT (div_quot)
  );

  assign pos_sum = {1'b0, pos_reg} + {1'b0, step_reg};

  // capture at one edge, ramp next interval, land at the one after
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cap_reg     <= `DCMP_RESET_CMD;
      seg_end_reg <= `DCMP_RESET_CMD;
      pos_reg     <= `DCMP_RESET_CMD;
      step_reg    <= 32'h00000000;
      ramp_reg    <= 1'b0;
    end else if (interp_edge) begin
      cap_reg     <= cmd_dist_reg;
      seg_end_reg <= cap_reg;
      pos_reg     <= seg_end_reg;
      ramp_reg    <= 1'b0;
    end else if (div_done) begin
      step_reg    <= div_quot;
      ramp_reg    <= 1'b1;
    end else if (ramp_reg) begin
      // clamp so the ramp never overshoots the segment end
      if (pos_sum >= {1'b0, seg_end_reg}) begin
        pos_reg  <= seg_end_reg;
        ramp_reg <= 1'b0;
      end else begin
        pos_reg  <= pos_sum[31:0];
      end
    end
  end

  // table fill; writes while running are dropped
  assign table_full = (wptr_reg == `DCMP_TABLE_LAST);

  always @(posedge CLK_SYS) begin
    if (wr_table && !run_en_reg && !table_full) begin
      table_mem[wptr_reg] <= {^WR_DATA, WR_DATA};
    end
  end

  // write pointer, cleared by the table clear action
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wptr_reg <= {PW{1'b0}};
    end else if (!run_en_reg) begin
      if (wr_ctrl && WR_DATA[`DCMP_CTRL_TABLE_CLR]) begin
        wptr_reg <= {PW{1'b0}};
      end else if (wr_table && !table_full) begin
        wptr_reg <= wptr_reg + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

  // control fields that steer the datapath
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      run_en_reg  <= 1'b0;
      clk_sel_reg <= 1'b0;
      pol_reg     <= 1'b0;
    end else if (wr_ctrl) begin
      run_en_reg  <= WR_DATA[`DCMP_CTRL_RUN_EN];
      clk_sel_reg <= WR_DATA[`DCMP_CTRL_CLK_SEL];
      pol_reg     <= WR_DATA[`DCMP_CTRL_POL];
    end
  end

  // current entry and its parity check
  assign cur_entry      = table_mem[cptr_reg];
  assign cur_parity_bad = cmp_pending && (^cur_entry);
  assign cmp_pending    = run_en_reg && (cptr_reg != wptr_reg);
  assign cmp_hit        = cmp_pending && (pos_reg > cur_entry[31:0]);

  assign force_we = wr_ctrl && WR_DATA[`DCMP_CTRL_FORCE_WE];
  assign run_rise = wr_ctrl && WR_DATA[`DCMP_CTRL_RUN_EN] && !run_en_reg;
  assign run_fall = wr_ctrl && !WR_DATA[`DCMP_CTRL_RUN_EN];

  // compare pointer walks the table one entry per hit
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cptr_reg <= {PW{1'b0}};
    end else if (run_rise) begin
      cptr_reg <= {PW{1'b0}};
    end else if (cmp_hit && !run_fall) begin
      cptr_reg <= cptr_reg + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // compare output; a forced value beats the comparison in the same cycle
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      out_reg <= 1'b0;
    end else if (force_we) begin
      // preset taken in any run state
      out_reg <= WR_DATA[`DCMP_CTRL_FORCE_VAL];
    end else if (run_rise || run_fall) begin
      // start and stop clear the output
      out_reg <= 1'b0;
    end else if (cmp_hit) begin
      out_reg <= ~out_reg;
    end
    // force enable clear: value bit ignored, only start, stop or a hit can change the output
  end

  // sticky memory error until table is cleared
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mem_err_reg <= 1'b0;
    end else if (cur_parity_bad) begin
      mem_err_reg <= 1'b1;
    end else if (wr_ctrl && WR_DATA[`DCMP_CTRL_TABLE_CLR] && !run_en_reg) begin
      mem_err_reg <= 1'b0;
    end
  end

  // last entry consumed: the held output is now final
  assign done_event = cmp_hit &&
    ((cptr_reg + {{(PW-1){1'b0}}, 1'b1}) == wptr_reg);

  assign irq_set[`DCMP_IRQ_TOGGLE] = cmp_hit;
  assign irq_set[`DCMP_IRQ_DONE]   = done_event;
  assign irq_set[`DCMP_IRQ_MEMERR] = cur_parity_bad;

  // sticky events, write one to clear, a new event wins over the clear
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_stat_reg <= {`DCMP_IRQ_WIDTH{1'b0}};
    end else begin
      irq_stat_reg <= (irq_stat_reg &
        ~(wr_irq_stat ? WR_DATA[`DCMP_IRQ_WIDTH-1:0]
                      : {`DCMP_IRQ_WIDTH{1'b0}})) | irq_set;
    end
  end

  // interrupt mask, all masked after reset
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_mask_reg <= {`DCMP_IRQ_WIDTH{1'b0}};
    end else if (wr_irq_mask) begin
      irq_mask_reg <= WR_DATA[`DCMP_IRQ_WIDTH-1:0];
    end
  end

  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // polarity flips the pin sense only, not the state
  assign TRIGGER_OUTPUT_PIN = out_reg ^ pol_reg;

  // read data valid only in the cycle after the strobe
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= 32'h00000000;
    end else if (RD_STB) begin
      case (ADDR)
        `DCMP_OFS_CMD_DIST: begin
          RD_DATA <= cmd_dist_reg;
        end
        `DCMP_OFS_TABLE_PORT: begin
          // entry now under comparison
          RD_DATA <= cur_entry[31:0];
        end
        `DCMP_OFS_CTRL: begin
          // force and clear are actions and read back as zero
          RD_DATA <= {run_en_reg, 1'b0, clk_sel_reg, 3'h0, pol_reg,
                      25'h0000000};
        end
        `DCMP_OFS_STATUS: begin
          RD_DATA <= {out_reg, 7'h00, wptr_reg, cptr_reg};
        end
        `DCMP_OFS_MEM_ERR: begin
          RD_DATA <= {31'h00000000, mem_err_reg};
        end
        `DCMP_OFS_IRQ_STATUS: begin
          RD_DATA <= {29'h00000000, irq_stat_reg};
        end
        `DCMP_OFS_IRQ_MASK: begin
          RD_DATA <= {29'h00000000, irq_mask_reg};
        end
        default: begin
          RD_DATA <= 32'h00000000;
        end
      endcase
    end else begin
      RD_DATA <= 32'h00000000;
    end
  end

endmodule

//--- dcmp_top_assertions.sv
// concurrent checks on the ports of the compare output stage
`timescale 1ns/10ps
module dcmp_chk (
  // clock and reset
  input wire        CLK_SYS,
  input wire        RESETN,
  // register port
  input wire [4:0]  ADDR,
  input wire [31:0] WR_DATA,
  input wire        WR_STB,
  input wire        RD_STB,
  input wire [31:0] RD_DATA,
  // trigger and interrupt
  input wire        TRIGGER_OUTPUT_PIN,
  input wire        IRQ
);
  reg       pol_reg;
  reg       run_reg;
  reg       sel_reg;
  reg       fv_reg;
  reg [2:0] msk_reg;
  wire      ctl_wr;
  assign ctl_wr = WR_STB && (ADDR == 5'h08);
  // shadow of control and mask fields as software wrote them
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pol_reg <= 1'b0;
      run_reg <= 1'b0;
      sel_reg <= 1'b0;
      fv_reg  <= 1'b0;
      msk_reg <= 3'h0;
    end else begin
      if (ctl_wr) begin
        pol_reg <= WR_DATA[25];
        run_reg <= WR_DATA[31];
        sel_reg <= WR_DATA[29];
        fv_reg  <= WR_DATA[27];
      end
      if (WR_STB && (ADDR == 5'h18)) begin
        msk_reg <= WR_DATA[2:0];
      end
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  AST_FORCE: assert property (ctl_wr && WR_DATA[26] |=>
    TRIGGER_OUTPUT_PIN == (fv_reg ^ pol_reg)) else $error("force lost");
  AST_START_LOW: assert property (ctl_wr && !WR_DATA[26] &&
    WR_DATA[31] && !run_reg |=> TRIGGER_OUTPUT_PIN == pol_reg)
    else $error("start not from low output");
  AST_STOP_LOW: assert property (ctl_wr && !WR_DATA[26] &&
    !WR_DATA[31] |=> TRIGGER_OUTPUT_PIN == pol_reg)
    else $error("stop did not clear output");
  AST_QUIET: assert property (!ctl_wr && !run_reg |=>
    $stable(TRIGGER_OUTPUT_PIN)) else $error("pin moved while stopped");
  AST_STATUS_OUT: assert property (RD_STB && ADDR == 5'h0c |=>
    RD_DATA[31] == ($past(TRIGGER_OUTPUT_PIN) ^ pol_reg))
    else $error("status output bit wrong");
  AST_CTRL_READ: assert property (RD_STB && ADDR == 5'h08 |=>
    RD_DATA == {run_reg, 1'b0, sel_reg, 3'h0, pol_reg, 25'h0})
    else $error("control readback wrong");
  AST_MEMERR: assert property (RD_STB && ADDR == 5'h10 |=>
    RD_DATA[31:1] == 31'h0) else $error("memory error spare bits");
  AST_UNMAPPED: assert property (RD_STB && ADDR > 5'h18 |=>
    RD_DATA == 32'h0) else $error("unmapped read not zero");
  AST_RD_IDLE: assert property (!RD_STB |=> RD_DATA == 32'h0)
    else $error("read data without read");
  AST_IRQ_MASK: assert property (msk_reg == 3'h0 |-> !IRQ)
    else $error("interrupt while all masked");
  // main scenarios reached
  cover property (ctl_wr && WR_DATA[26]);
  cover property (IRQ);
  cover property (RD_STB && ADDR == 5'h0c && TRIGGER_OUTPUT_PIN);
endmodule

bind dcmp_top dcmp_chk i_chk (
  .CLK_SYS            (CLK_SYS),
  .RESETN             (RESETN),
  .ADDR               (ADDR),
  .WR_DATA            (WR_DATA),
  .WR_STB             (WR_STB),
  .RD_STB             (RD_STB),
  .RD_DATA            (RD_DATA),
  .TRIGGER_OUTPUT_PIN (TRIGGER_OUTPUT_PIN),
  .IRQ                (IRQ)
);

//--- dcmp_clk_model.sv
// clock source model driving the servo and phase interpolation pins
`timescale 1ns/10ps
module dcmp_clk_model #(
  parameter PH_HALF = 1250,
  parameter SRV_DIV = 2
) (
  // run controls
  input  wire en_phase,
  input  wire en_servo,
  // interpolation clocks, low while stopped
  output reg  PHASE_CLK,
  output reg  SERVO_CLK
);
  reg     src;
  integer cnt;
  initial begin
    src = 1'b0;
    cnt = 0;
    PHASE_CLK = 1'b0;
    SERVO_CLK = 1'b0;
  end
  always #(PH_HALF) src = ~src;
  // one shared source
  // servo is a whole division of phase so their edges stay aligned
  always @(src) begin
    if (src) begin
      cnt = (cnt + 1) % SRV_DIV;
    end
    PHASE_CLK = en_phase & src;
    SERVO_CLK = en_servo & src & (cnt == 0);
  end
endmodule

//--- test_distance_compare_output.sv
// self-checking bench for the distance compare output stage
`timescale 1ns/10ps
module test_distance_compare_output;
  localparam ALL  = 32'hffffffff;
  localparam PTRS = 32'h80000fff;
  localparam B0   = 1'b0;
  localparam B1   = 1'b1;
  reg  clk_sys, resetn, wr_stb, rd_stb, en_ph, en_sv, rd_q, sel;
  reg  [4:0]  addr;
  reg  [31:0] wr_data, base, e0, d;
  reg  [31:0] exp_q[$];
  reg  [31:0] msk_q[$];
  wire [31:0] rd_data;
  wire servo_clk, phase_clk, pin, irq;
  integer err_count, cmp_count, seed, cyc, i;
  dcmp_top i_dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .SERVO_CLK(servo_clk), .PHASE_CLK(phase_clk), .ADDR(addr),
    .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RD_DATA(rd_data), .TRIGGER_OUTPUT_PIN(pin), .IRQ(irq));
  dcmp_clk_model #(.PH_HALF(1600), .SRV_DIV(2)) i_clk (.en_phase(en_ph),
    .en_servo(en_sv), .PHASE_CLK(phase_clk), .SERVO_CLK(servo_clk));
  always #25 clk_sys = ~clk_sys;
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    begin
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      rd_stb <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // expected read data noted here, compared by the watcher below
  task rd(input [4:0] a, input [31:0] e, input [31:0] m);
    begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      addr <= a;
      rd_stb <= 1'b1;
      wr_stb <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task idle(input integer n);
    begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      repeat (n) @(posedge clk_sys);
    end
  endtask
  // wait one selected interp edge plus sync and a few cycles
  task edge_sel(input s);
    begin
      if (s) @(posedge phase_clk);
      else @(posedge servo_clk);
      repeat (10) @(posedge clk_sys);
    end
  endtask
  function [31:0] ctl(input r, c, s, v, e, p);
    ctl = {r, c, s, 1'b0, v, e, p, 25'h0};
  endfunction
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_q) begin
      chk("rd_data", exp_q.pop_front(), rd_data & msk_q.pop_front());
    end
    rd_q <= rd_stb;
  end
  // hang guard, the run needs well under half of this
  always @(posedge clk_sys) begin
    if (!resetn) cyc = 0;
    else cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  initial begin
    {clk_sys, resetn, wr_stb, rd_stb, en_ph, en_sv} = 6'h00;
    {addr, wr_data, err_count, cmp_count, base} = '0;
    seed = 25238;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(5'h08, 32'h0, ALL);
    rd(5'h0c, 32'h0, ALL);
    rd(5'h10, 32'h0, ALL);
    rd(5'h14, 32'h0, ALL);
    rd(5'h1c, 32'h0, ALL);
    idle(2);
    $display("test reset done");
    // every polarity and preset value through the force field
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h08, ctl(B0, B0, B0, i[0], B1, i[1]));
      rd(5'h0c, {i[0], 31'h0}, PTRS);
      idle(1);
      chk("pin", {31'h0, i[0] ^ i[1]}, {31'h0, pin});
    end
    wr(5'h08, ctl(B1, B0, B0, B0, B0, B0));
    wr(5'h08, ctl(B1, B0, B0, B1, B1, B0));
    wr(5'h08, ctl(B1, B0, B0, B0, B0, B0));
    rd(5'h0c, 32'h80000000, PTRS);
    wr(5'h08, ctl(B0, B0, B0, B0, B0, B0));
    rd(5'h0c, 32'h0, PTRS);
    wr(5'h08, ctl(B0, B0, B0, B1, B1, B0));
    wr(5'h08, ctl(B1, B0, B0, B0, B0, B0));
    rd(5'h0c, 32'h0, PTRS);
    wr(5'h08, ctl(B0, B1, B0, B0, B0, B0));
    for (i = 0; i < 4096; i = i + 1) wr(5'h04, i[31:0]);
    rd(5'h0c, 32'h00fff000, 32'h00fff000);
    idle(1);
    $display("test force and table done");
    for (i = 0; i < 2; i = i + 1) begin
      sel = i[0];
      e0 = base + 32'h10 + ($random(seed) & 32'hff);
      d = e0 + 32'h20 + ($random(seed) & 32'hff);
      wr(5'h08, ctl(B0, B0, sel, B0, B0, B0));
      wr(5'h08, ctl(B0, B1, sel, B0, B0, B0));
      wr(5'h04, e0);
      wr(5'h04, e0 + 32'h5);
      wr(5'h04, e0 + 32'h9);
      wr(5'h08, ctl(B1, B0, sel, B0, B0, B0));
      wr(5'h00, d);
      // table append while running must be dropped
      wr(5'h04, 32'h0);
      rd(5'h00, d, ALL);
      rd(5'h04, e0, ALL);
      idle(1);
      en_ph <= !sel;
      en_sv <= sel;
      edge_sel(!sel);
      edge_sel(!sel);
      edge_sel(!sel);
      rd(5'h0c, 32'h0, PTRS);
      idle(1);
      en_ph <= sel;
      en_sv <= !sel;
      edge_sel(sel);
      edge_sel(sel);
      rd(5'h0c, 32'h0, PTRS);
      idle(1);
      edge_sel(sel);
      rd(5'h0c, 32'h80003003, ALL);
      // clear refused and no restart while already running
      wr(5'h08, ctl(B1, B1, sel, B0, B0, B0));
      rd(5'h0c, 32'h80003003, ALL);
      rd(5'h14, 32'h3, 32'h3);
      idle(1);
      en_ph <= 1'b0;
      en_sv <= 1'b0;
      base = d;
      $display("test interpolation clock %0d done", i);
    end
    wr(5'h18, 32'h4);
    idle(1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(5'h18, 32'h1);
    idle(1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(5'h18, 32'h1, ALL);
    wr(5'h14, 32'h3);
    rd(5'h14, 32'h0, 32'h7);
    // three idle edges so the watcher compares before the run ends
    idle(3);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    complete_run;
  end
endmodule
